// ### design/operand_decode_core.sv
// Decode and execute core for a 16-bit RISC instruction set.
// Assumes a memory and peripheral bus whose read data is valid in the cycle of the address.
`timescale 1ns/1ps
module operand_decode_core
  import core_pkg::*;
#(
  parameter logic [15:0] VECTOR_ADDR = RESET_VEC_ADDR
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [1:0]       mem_be,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  output logic             illegal_op,
  output logic [15:0]      pc_value,
  output logic [15:0]      status_value
);
  import core_pkg::*;

  if (VECTOR_ADDR[0] != 1'b0) begin : g_chk
    $error("VECTOR_ADDR must be word aligned");
  end

  regs_if rf ();
  reg_store u_store (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rf      (rf)
  );

  state_e      state, next_state;
  logic [15:0] ir, next_ir;
  logic [15:0] src, next_src;
  logic [15:0] dst, next_dst;
  logic [15:0] src_ea, next_src_ea;
  logic [15:0] dst_ea, next_dst_ea;

  logic [15:0] w;
  logic        fmt_jump, fmt_single, fmt_dual, bad;
  logic [3:0]  sreg, dreg;
  logic [1:0]  as;
  logic        ad, bw, const_hit, src_direct, needs_ext, imm, flow_op, fast;
  logic [15:0] const_val, sval, dval, op_s, op_d, jmp_target;
  logic        jmp_take;
  alu_s        alu_o;

  function automatic logic [15:0] lane(input logic [15:0] d, input logic [15:0] a,
                                       input logic b);
    if (!b) return d;
    return a[0] ? {8'h00, d[15:8]} : {8'h00, d[7:0]};
  endfunction

  function automatic logic cond_ok(input logic [2:0] c, input logic [15:0] s);
    case (c)
      3'h0:    return !s[FLAG_Z];
      3'h1:    return s[FLAG_Z];
      3'h2:    return !s[FLAG_C];
      3'h3:    return s[FLAG_C];
      3'h4:    return s[FLAG_N];
      3'h5:    return s[FLAG_N] == s[FLAG_V];
      3'h6:    return s[FLAG_N] != s[FLAG_V];
      default: return 1'b1;
    endcase
  endfunction

  // Decimal add is not given a BCD adder; it behaves as a binary add
  function automatic alu_s alu(input logic [3:0] op, input logic dual, input logic [2:0] sop,
                               input logic b8, input logic [15:0] s, input logic [15:0] d,
                               input logic [15:0] sr);
    alu_s        o;
    logic [16:0] sum;
    logic [15:0] a, b, r, m, top;
    logic        cin, arith, upd, ma, mb, mr;
    m     = b8 ? 16'h00ff : 16'hffff;
    top   = b8 ? 16'h0080 : 16'h8000;
    o.wb  = 1'b1;
    o.sr  = sr;
    a     = d & m;
    b     = s & m;
    cin   = 1'b0;
    arith = 1'b0;
    upd   = 1'b0;
    r     = 16'h0000;
    if (dual) begin
      case (op)
        OP_MOV:         r = b;
        OP_ADD, OP_DADD: arith = 1'b1;
        OP_ADDC:        begin arith = 1'b1; cin = sr[FLAG_C]; end
        OP_SUBC:        begin arith = 1'b1; b = ~s & m; cin = sr[FLAG_C]; end
        OP_SUB:         begin arith = 1'b1; b = ~s & m; cin = 1'b1; end
        OP_CMP:         begin arith = 1'b1; b = ~s & m; cin = 1'b1; o.wb = 1'b0; end
        OP_BIT:         begin r = a & b; upd = 1'b1; o.wb = 1'b0; end
        OP_BIC:         r = a & ~b;
        OP_BIS:         r = a | b;
        OP_XOR:         begin r = a ^ b; upd = 1'b1; end
        default:        begin r = a & b; upd = 1'b1; end
      endcase
    end else begin
      case (sop)
        SOP_RRC:  begin r = (b >> 1) | (top & {16{sr[FLAG_C]}}); upd = 1'b1; end
        SOP_RRA:  begin r = (b >> 1) | (b & top); upd = 1'b1; end
        SOP_SWPB: r = {s[7:0], s[15:8]};
        SOP_SXT:  begin r = {{8{s[7]}}, s[7:0]}; upd = 1'b1; end
        default:  o.wb = 1'b0;
      endcase
    end
    sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    if (arith) begin
      r   = sum[15:0];
      upd = 1'b1;
    end
    r  = r & m;
    ma = |(a & top);
    mb = |(b & top);
    mr = |(r & top);
    if (upd) begin
      o.sr[FLAG_N] = mr;
      o.sr[FLAG_Z] = (r == 16'h0000);
      o.sr[FLAG_C] = arith ? (b8 ? sum[8] : sum[16]) : (!dual && sop != SOP_SXT) ? s[0]
                                                     : (r != 16'h0000);
      o.sr[FLAG_V] = arith ? (ma == mb && mr != ma) : (dual && op == OP_XOR) ? (ma && mb)
                                                    : 1'b0;
    end
    o.res = r;
    return o;
  endfunction

  // Decode works on the word arriving from memory during fetch, else on the held word
  always_comb begin
    w          = (state == S_FETCH) ? mem_rdata : ir;
    fmt_jump   = w[15:13] == JUMP_TAG;
    fmt_single = w[15:10] == SINGLE_TAG;
    fmt_dual   = w[15:12] >= OP_MOV;
    bad        = !(fmt_jump || fmt_dual || (fmt_single && w[9:7] <= SOP_CALL));
    sreg       = fmt_dual ? w[11:8] : w[3:0];
    dreg       = w[3:0];
    as         = w[5:4];
    ad         = w[7] && fmt_dual;
    bw         = w[6];
    flow_op    = fmt_single && (w[9:7] == SOP_PUSH || w[9:7] == SOP_CALL);
    // Index 2 in modes 2/3 and index 3 in all modes produce constants
    const_hit  = sreg == CONST_IDX || (sreg == SR_IDX && as[1]);
    case ({sreg == CONST_IDX, as})
      3'h4:    const_val = 16'h0000;
      3'h5:    const_val = 16'h0001;
      3'h6:    const_val = 16'h0002;
      3'h7:    const_val = 16'hffff;
      3'h2:    const_val = 16'h0004;
      default: const_val = 16'h0008;
    endcase
    src_direct = as == AM_REG || const_hit;
    imm        = as == AM_INC && sreg == PC_IDX;
    needs_ext  = !const_hit && (as == AM_IDX || imm);
    fast       = src_direct && !ad && !flow_op;
    rf.ra_idx  = sreg;
    rf.rb_idx  = dreg;
    sval       = const_hit ? const_val : (sreg == PC_IDX && state == S_FETCH) ? rf.pc + WORD_STEP
                                                                        : rf.ra_data;
    dval       = (dreg == PC_IDX && state == S_FETCH) ? rf.pc + WORD_STEP : rf.rb_data;
    op_s       = (state == S_FETCH) ? sval : src;
    op_d       = (state == S_FETCH || !ad) ? dval : dst;
    alu_o      = alu(w[15:12], fmt_dual, w[9:7], bw, op_s, op_d, rf.sr);
    jmp_target = rf.pc + WORD_STEP + {{5{w[9]}}, w[9:0], 1'b0};
    jmp_take   = cond_ok(w[12:10], rf.sr);
  end

  always_comb begin
    next_state  = state;
    next_ir     = ir;
    next_src    = src;
    next_dst    = dst;
    next_src_ea = src_ea;
    next_dst_ea = dst_ea;
    mem_addr    = rf.pc;
    mem_rd      = 1'b0;
    mem_wr      = 1'b0;
    mem_be      = 2'h3;
    mem_wdata   = 16'h0000;
    illegal_op  = 1'b0;
    rf.wr_en    = 1'b0;
    rf.wr_idx   = dreg;
    rf.wr_data  = alu_o.res;
    rf.pc_wr    = 1'b0;
    rf.pc_next  = rf.pc + WORD_STEP;
    rf.sp_wr    = 1'b0;
    rf.sp_next  = rf.sp - WORD_STEP;
    rf.sr_wr    = 1'b0;
    rf.sr_next  = alu_o.sr;
    case (state)
      S_VECTOR: begin
        mem_addr   = VECTOR_ADDR;
        mem_rd     = 1'b1;
        rf.pc_wr   = 1'b1;
        rf.pc_next = mem_rdata;
        next_state = S_FETCH;
      end
      S_FETCH: begin
        mem_rd   = 1'b1;
        next_ir  = mem_rdata;
        rf.pc_wr = 1'b1;
        if (fmt_jump) begin
          if (jmp_take) begin
            rf.pc_next = jmp_target;
          end
        end else if (bad) begin
          illegal_op = 1'b1;
        end else if (fast) begin
          rf.wr_en = alu_o.wb;
          rf.sr_wr = 1'b1;
        end else begin
          next_src    = sval;
          next_src_ea = rf.ra_data;
          next_state  = src_direct ? (ad ? S_DST_EXT : S_EXEC)
                                   : (needs_ext ? S_SRC_EXT : S_SRC_RD);
        end
      end
      S_SRC_EXT: begin
        mem_rd   = 1'b1;
        rf.pc_wr = 1'b1;
        if (imm) begin
          next_src   = mem_rdata;
          next_state = ad ? S_DST_EXT : S_EXEC;
        end else begin
          // Symbolic mode sees PC at the extension word; absolute mode uses base zero
          next_src_ea = mem_rdata + ((sreg == SR_IDX) ? 16'h0000 : rf.ra_data);
          next_state  = S_SRC_RD;
        end
      end
      S_SRC_RD: begin
        mem_addr    = src_ea;
        mem_rd      = 1'b1;
        next_src    = lane(mem_rdata, src_ea, bw);
        next_dst_ea = src_ea;
        if (as == AM_INC) begin
          rf.wr_en   = 1'b1;
          rf.wr_idx  = sreg;
          rf.wr_data = rf.ra_data + (bw ? BYTE_STEP : WORD_STEP);
        end
        next_state = ad ? S_DST_EXT : S_EXEC;
      end
      S_DST_EXT: begin
        mem_rd      = 1'b1;
        rf.pc_wr    = 1'b1;
        next_dst_ea = mem_rdata + ((dreg == SR_IDX) ? 16'h0000 : rf.rb_data);
        next_state  = S_DST_RD;
      end
      S_DST_RD: begin
        mem_addr   = dst_ea;
        mem_rd     = 1'b1;
        next_dst   = lane(mem_rdata, dst_ea, bw);
        next_state = S_EXEC;
      end
      default: begin
        next_state = S_FETCH;
        mem_be     = bw ? (mem_addr[0] ? 2'h2 : 2'h1) : 2'h3;
        if (flow_op) begin
          // Push and call store below the stack pointer and move it there in the same cycle
          rf.sp_wr  = 1'b1;
          mem_addr  = rf.sp - WORD_STEP;
          mem_wr    = 1'b1;
          mem_be    = 2'h3;
          mem_wdata = (w[9:7] == SOP_CALL) ? rf.pc : src;
          if (w[9:7] == SOP_CALL) begin
            rf.pc_wr   = 1'b1;
            rf.pc_next = src;
          end
        end else begin
          rf.sr_wr = 1'b1;
          if (fmt_dual ? ad : as != AM_REG) begin
            mem_addr  = dst_ea;
            mem_wr    = alu_o.wb;
            mem_be    = bw ? (dst_ea[0] ? 2'h2 : 2'h1) : 2'h3;
            mem_wdata = bw ? {alu_o.res[7:0], alu_o.res[7:0]} : alu_o.res;
          end else begin
            rf.wr_en = alu_o.wb;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state  <= S_VECTOR;
      ir     <= 16'h0000;
      src    <= 16'h0000;
      dst    <= 16'h0000;
      src_ea <= 16'h0000;
      dst_ea <= 16'h0000;
    end else begin
      state  <= next_state;
      ir     <= next_ir;
      src    <= next_src;
      dst    <= next_dst;
      src_ea <= next_src_ea;
      dst_ea <= next_dst_ea;
    end
  end

  assign pc_value     = rf.pc;
  assign status_value = rf.sr;

  reg_reg_one_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_FETCH && fmt_dual && fast |=> state == S_FETCH)
    else $error("register operation took more than one cycle");
  ne_taken_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_FETCH && fmt_jump && w[12:10] == JC_NE && !rf.sr[FLAG_Z]
    |=> rf.pc == $past(jmp_target))
    else $error("not-equal jump not taken");
  ne_held_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_FETCH && fmt_jump && w[12:10] == JC_NE && rf.sr[FLAG_Z]
    |=> rf.pc == $past(rf.pc) + WORD_STEP)
    else $error("not-equal jump taken with zero set");
  autoinc_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_SRC_RD && as == AM_INC && !bw
    |-> rf.wr_en && rf.wr_idx == sreg && rf.wr_data == rf.ra_data + WORD_STEP)
    else $error("autoincrement did not advance by two");
  dst_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_DST_EXT |-> fmt_dual && ir[7])
    else $error("destination extension without indexed destination");
  byte_lane_a: assert property (@(posedge ref_clk) disable iff (reset)
    mem_wr && bw && !flow_op |-> mem_be != 2'h3 && mem_wdata[15:8] == mem_wdata[7:0])
    else $error("byte write used both lanes");
  src_bus_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_SRC_RD |-> mem_rd && mem_addr == src_ea)
    else $error("source operand not read over the bus");
  bad_op_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_FETCH && !fmt_jump && !fmt_single && !fmt_dual |-> illegal_op)
    else $error("unrecognised format not flagged");
  finish_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_SRC_EXT |-> ##[2:5] state == S_FETCH)
    else $error("addressed operation did not complete");
  const_gen_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == S_FETCH && fmt_dual && sreg == CONST_IDX && as == AM_IDX |-> sval == 16'h0001)
    else $error("constant generator gave wrong value");
endmodule // operand_decode_core

// ### design/core_pkg.sv
// Constants, encodings and shared types for the 16-bit operand decode core.
// Assumes a single 125 MHz clock and a memory that answers reads in the same cycle.
package core_pkg;
  localparam int          DATA_W         = 16;
  localparam int          REG_COUNT      = 16;
  localparam logic [3:0]  PC_IDX         = 4'h0;
  localparam logic [3:0]  SP_IDX         = 4'h1;
  localparam logic [3:0]  SR_IDX         = 4'h2;
  localparam logic [3:0]  CONST_IDX      = 4'h3;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] RESET_VEC_ADDR = 16'hfffe;
  localparam int          FLAG_C         = 0;
  localparam int          FLAG_Z         = 1;
  localparam int          FLAG_N         = 2;
  localparam int          FLAG_V         = 8;
  localparam logic [1:0]  AM_REG         = 2'h0;
  localparam logic [1:0]  AM_IDX         = 2'h1;
  localparam logic [1:0]  AM_IND         = 2'h2;
  localparam logic [1:0]  AM_INC         = 2'h3;
  localparam logic [3:0]  OP_MOV  = 4'h4;
  localparam logic [3:0]  OP_ADD  = 4'h5;
  localparam logic [3:0]  OP_ADDC = 4'h6;
  localparam logic [3:0]  OP_SUBC = 4'h7;
  localparam logic [3:0]  OP_SUB  = 4'h8;
  localparam logic [3:0]  OP_CMP  = 4'h9;
  localparam logic [3:0]  OP_DADD = 4'ha;
  localparam logic [3:0]  OP_BIT  = 4'hb;
  localparam logic [3:0]  OP_BIC  = 4'hc;
  localparam logic [3:0]  OP_BIS  = 4'hd;
  localparam logic [3:0]  OP_XOR  = 4'he;
  localparam logic [2:0]  SOP_RRC  = 3'h0;
  localparam logic [2:0]  SOP_SWPB = 3'h1;
  localparam logic [2:0]  SOP_RRA  = 3'h2;
  localparam logic [2:0]  SOP_SXT  = 3'h3;
  localparam logic [2:0]  SOP_PUSH = 3'h4;
  localparam logic [2:0]  SOP_CALL = 3'h5;
  localparam logic [2:0]  JC_NE    = 3'h0;
  localparam logic [5:0]  SINGLE_TAG = 6'h04;
  localparam logic [2:0]  JUMP_TAG   = 3'h1;
  localparam logic [15:0] WORD_STEP  = 16'h0002;
  localparam logic [15:0] BYTE_STEP  = 16'h0001;

  typedef enum logic [2:0] {
    S_VECTOR, S_FETCH, S_SRC_EXT, S_SRC_RD, S_DST_EXT, S_DST_RD, S_EXEC
  } state_e;

  typedef struct packed {
    logic        wb;
    logic [15:0] sr;
    logic [15:0] res;
  } alu_s;
endpackage

// ### design/regs_if.sv
// Register file access bundle between the decode core and its register store.
// Assumes one writer (the core) and combinational read ports.
`timescale 1ns/1ps
interface regs_if;
  import core_pkg::*;
  logic [3:0]  ra_idx;
  logic [15:0] ra_data;
  logic [3:0]  rb_idx;
  logic [15:0] rb_data;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [15:0] wr_data;
  logic        pc_wr;
  logic [15:0] pc_next;
  logic        sp_wr;
  logic [15:0] sp_next;
  logic        sr_wr;
  logic [15:0] sr_next;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] sr;
  modport core  (output ra_idx, rb_idx, wr_en, wr_idx, wr_data, pc_wr, pc_next,
                 sp_wr, sp_next, sr_wr, sr_next,
                 input  ra_data, rb_data, pc, sp, sr);
  modport store (input  ra_idx, rb_idx, wr_en, wr_idx, wr_data, pc_wr, pc_next,
                 sp_wr, sp_next, sr_wr, sr_next,
                 output ra_data, rb_data, pc, sp, sr);
endinterface

// ### design/reg_store.sv
// Sixteen-entry register store with dedicated update paths for PC, SP and SR.
// Assumes the core never needs more than one general write per cycle.
`timescale 1ns/1ps
module reg_store
  import core_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  regs_if.store     rf
);
  logic [15:0] entry      [REG_COUNT];
  logic [15:0] next_entry [REG_COUNT];

  // General write wins over the dedicated paths, so an instruction targeting PC or SR
  // overrides the automatic increment or flag update.
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
    always_comb begin
      next_entry[i] = entry[i];
      if (rf.wr_en && rf.wr_idx == 4'(i)) begin
        next_entry[i] = rf.wr_data;
      end else if (4'(i) == PC_IDX && rf.pc_wr) begin
        next_entry[i] = rf.pc_next;
      end else if (4'(i) == SP_IDX && rf.sp_wr) begin
        next_entry[i] = rf.sp_next;
      end else if (4'(i) == SR_IDX && rf.sr_wr) begin
        next_entry[i] = rf.sr_next;
      end
      if (4'(i) == CONST_IDX) begin
        next_entry[i] = REG_RESET;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        entry[i] <= REG_RESET;
      end else begin
        entry[i] <= next_entry[i];
      end
    end
  end

  // Index 3 holds no storage of its own; constants are produced in the core
  assign rf.ra_data = (rf.ra_idx == CONST_IDX) ? REG_RESET : entry[rf.ra_idx];
  assign rf.rb_data = (rf.rb_idx == CONST_IDX) ? REG_RESET : entry[rf.rb_idx];
  assign rf.pc      = entry[PC_IDX];
  assign rf.sp      = entry[SP_IDX];
  assign rf.sr      = entry[SR_IDX];

  gp_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    rf.wr_en && rf.wr_idx > CONST_IDX |=> entry[$past(rf.wr_idx)] == $past(rf.wr_data))
    else $error("general register write lost");
  const_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    rf.ra_idx == CONST_IDX |-> rf.ra_data == 16'h0000)
    else $error("constant generator register not zero");
endmodule // reg_store

// ### tb/mem_model.sv
// Zero-latency memory and peripheral space on the core's shared buses.
// Assumes the core samples read data in the same cycle as the address.
`timescale 1ns/1ps
module mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [1:0]  mem_be,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] junk = 16'h5a5a;
  // Moving pattern outside reads, so a stale answer is never mistaken for data
  assign mem_rdata = mem_rd ? mem[mem_addr[15:1]] : junk;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
  end
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (mem_wr && mem_be[0]) mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
    if (mem_wr && mem_be[1]) mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
  end
endmodule // mem_model

// ### tb/testbench.sv
// Self-checking bench: runs one program through the core and a zero-latency memory.
// Assumes the reset vector at 16'hfffe and the encodings of core_pkg.
`timescale 1ns/1ps
module testbench;
  import core_pkg::*;
  logic        ref_clk;
  logic        reset;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [1:0]  mem_be;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        illegal_op;
  logic [15:0] pc_value;
  logic [15:0] status_value;
  int          err_count;
  int          comparisons;
  int          seed;
  int          ill_n;
  int          add_n;
  logic [15:0] pa, add_at, ill_at, halt_at, imm1, imm2, sum, d0, d1, d2, sr_add, sr_cmp, res;
  logic [16:0] sum17;
  logic [33:0] exq [$];
  logic [33:0] w;
  bit          add_prev;

  operand_decode_core dut (.ref_clk(ref_clk), .reset(reset), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .illegal_op(illegal_op), .pc_value(pc_value),
    .status_value(status_value));
  mem_model far_mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] dual(logic [3:0] op, logic [3:0] s, logic ad, logic bw,
                                       logic [1:0] am, logic [3:0] d);
    return {op, s, ad, bw, am, d};
  endfunction

  function automatic logic [15:0] jump_if_not_equal(logic [9:0] off);
    return {JUMP_TAG, JC_NE, off};
  endfunction

  task automatic put(input logic [15:0] v);
    far_mem.mem[pa[15:1]] = v;
    pa = pa + 16'h0002;
  endtask

  task automatic expw(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    exq.push_back({be, a, d});
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Every bus write is checked against the reference model in program order
  always @(posedge ref_clk) begin
    if (!reset) begin
      if (mem_wr) begin
        if (exq.size() == 0) begin
          check16(mem_addr, 16'hffff, "write not expected");
        end else begin
          w = exq.pop_front();
          check16(mem_addr, w[31:16], "write address");
          check16(mem_wdata, w[15:0], "write data");
          check16({14'h0, mem_be}, {14'h0, w[33:32]}, "byte enables");
        end
      end
      if (illegal_op === 1'b1) begin
        ill_n++;
        check16(mem_addr, ill_at, "illegal word address");
      end
      if (add_prev) begin
        add_n++;
        check16(mem_addr, add_at + 16'h0002, "fetch after reg-reg op");
      end
      add_prev = (mem_rd === 1'b1) && (mem_addr === add_at);
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    seed = 32'h4d9d;
    reset = 1'b1;
    #1;
    imm1 = $random(seed);
    imm2 = $random(seed) | 16'h0001;
    d0 = $random(seed);
    d1 = $random(seed);
    d2 = $random(seed);
    sum17 = {1'b0, imm1} + {1'b0, imm2};
    sum = sum17[15:0];
    sr_add = {7'h0, (imm1[15] == imm2[15]) && (sum[15] != imm1[15]), 5'h0, sum[15],
              sum == 16'h0000, sum17[16]};
    res = sum - imm1;
    sr_cmp = {7'h0, (sum[15] != imm1[15]) && (res[15] != sum[15]), 5'h0, res[15],
              res == 16'h0000, sum >= imm1};
    far_mem.mem[15'h7fff] = 16'h1000;
    far_mem.mem[15'h0180] = d0;
    far_mem.mem[15'h0181] = d2;
    far_mem.mem[15'h0182] = d1;
    pa = 16'h1000;
    put(dual(OP_MOV, PC_IDX, 1'b0, 1'b0, AM_INC, 4'h4)); put(imm1);
    put(dual(OP_MOV, PC_IDX, 1'b0, 1'b0, AM_INC, 4'h5)); put(imm2);
    add_at = pa;
    put(dual(OP_ADD, 4'h4, 1'b0, 1'b0, AM_REG, 4'h5));
    put(dual(OP_MOV, SR_IDX, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h0210);
    expw(16'h0210, sr_add, 2'h3);
    put(dual(OP_MOV, 4'h5, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h0200);
    expw(16'h0200, sum, 2'h3);
    put(dual(OP_MOV, 4'h4, 1'b1, 1'b1, AM_REG, SR_IDX)); put(16'h0203);
    expw(16'h0203, {imm1[7:0], imm1[7:0]}, 2'h2);
    put(dual(OP_MOV, PC_IDX, 1'b0, 1'b0, AM_INC, 4'ha)); put(16'h0300);
    put(dual(OP_MOV, 4'ha, 1'b0, 1'b0, AM_INC, 4'hb));
    put(dual(OP_MOV, 4'ha, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h0204);
    expw(16'h0204, 16'h0302, 2'h3);
    put(dual(OP_MOV, 4'hb, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h0206);
    expw(16'h0206, d0, 2'h3);
    put(dual(OP_MOV, 4'ha, 1'b1, 1'b0, AM_IDX, 4'ha)); put(16'h0002); put(16'h0006);
    expw(16'h0308, d1, 2'h3);
    put(dual(OP_MOV, 4'ha, 1'b1, 1'b0, AM_IND, SR_IDX)); put(16'h020a);
    expw(16'h020a, d2, 2'h3);
    put(dual(OP_CMP, 4'h4, 1'b0, 1'b0, AM_REG, 4'h4));
    put(jump_if_not_equal(10'h002));
    put(dual(OP_MOV, CONST_IDX, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h020e);
    expw(16'h020e, 16'h0000, 2'h3);
    put(dual(OP_CMP, 4'h4, 1'b0, 1'b0, AM_REG, 4'h5));
    put(jump_if_not_equal(10'h002));
    put(dual(OP_MOV, 4'h4, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h020c);
    put(dual(OP_MOV, PC_IDX, 1'b0, 1'b0, AM_INC, SP_IDX)); put(16'h0280);
    put({SINGLE_TAG, SOP_PUSH, 1'b0, AM_REG, 4'h5});
    expw(16'h027e, sum, 2'h3);
    ill_at = pa;
    put(16'h0000);
    put(dual(OP_MOV, SP_IDX, 1'b1, 1'b0, AM_REG, SR_IDX)); put(16'h0212);
    expw(16'h0212, 16'h027e, 2'h3);
    // Constant sources need no extension word, so these take no immediate
    put(dual(OP_MOV, CONST_IDX, 1'b1, 1'b0, AM_IDX, SR_IDX)); put(16'h0214);
    expw(16'h0214, 16'h0001, 2'h3);
    put(dual(OP_MOV, SR_IDX, 1'b1, 1'b0, AM_INC, SR_IDX)); put(16'h0216);
    expw(16'h0216, 16'h0008, 2'h3);
    // Unconditional jump onto itself parks the core at the end
    halt_at = pa;
    put(16'h3fff);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 2000 && !(mem_rd === 1'b1 && mem_addr === halt_at); i++) begin
      @(posedge ref_clk);
    end
    check16(mem_addr, halt_at, "program end reached");
    check16(16'(exq.size()), 16'h0000, "writes left over");
    check16(16'(ill_n), 16'h0001, "illegal pulses");
    check16(16'(add_n), 16'h0001, "reg-reg fetches seen");
    check16(pc_value, halt_at, "program counter");
    check16(status_value, sr_cmp, "status after compare");
    $display("program test: done");
    tally_and_finish;
  end
endmodule // testbench
